// ==== rtl/tlih_pkg.sv ====
// Purpose: Constants and types for the two-level interrupt handler.
// Assumes: APB byte addresses, 32-bit data, one aligned word per register.
// Notes:   Source index 0..12 is also the fixed tie-break order.
package tlih_pkg;

  localparam int NSRC = 13;

  // Register byte offsets
  localparam logic [7:0] OFF_EN_PRI  = 8'h00;
  localparam logic [7:0] OFF_EN_EXT  = 8'h04;
  localparam logic [7:0] OFF_LVL_PRI = 8'h08;
  localparam logic [7:0] OFF_LVL_EXT = 8'h0C;
  localparam logic [7:0] OFF_PEND    = 8'h10;
  localparam logic [7:0] OFF_PINCFG  = 8'h14;
  localparam logic [7:0] OFF_STATUS  = 8'h18;

  // Field positions
  localparam int GLOB_BIT = 7;
  localparam int PRI_SRCS = 7;
  localparam int POL0_BIT = 0;
  localparam int POL1_BIT = 1;
  localparam int SNS0_BIT = 2;
  localparam int SNS1_BIT = 3;
  localparam int ST_REQ   = 0;
  localparam int ST_INSVC = 1;
  localparam int ST_LVL   = 3;
  localparam int ST_SRC   = 4;
  localparam int ST_HOLD  = 8;

  // Bit positions of sources 7..12 in the extended enable/level registers
  localparam logic [17:0] EXT_POS = {3'h7, 3'h5, 3'h4, 3'h3, 3'h2, 3'h0};

  // External request lanes
  localparam int EXT0_SRC = 0;
  localparam int EXT1_SRC = 2;

  // Reset values
  localparam logic [NSRC-1:0] RST_VEC = 13'h0000;
  localparam logic [3:0]      RST_CFG = 4'h0;

  // Sources whose flag is cleared by hardware on vectoring
  localparam logic [NSRC-1:0] HW_CLR_MASK = 13'h000F;

  // Vector = base + 8 * order; orders 8 and 13 are skipped
  localparam logic [15:0] VEC_BASE  = 16'h0003;
  localparam logic [51:0] SRC_ORDER = {4'hE, 4'hC, 4'hB, 4'hA, 4'h9,
                                       4'h7, 4'h6, 4'h5, 4'h4, 4'h3,
                                       4'h2, 4'h1, 4'h0};

  typedef struct packed {
    logic [15:0] vector;
    logic        level;
    logic [3:0]  src;
  } tlih_call_t;

endpackage

// ==== rtl/tlih_handler.sv ====
// Purpose: Two-level interrupt handler with APB register access.
// Assumes: CPU sequencer pulses instr_done and ret_done on pclk.
// Notes:   External request pins are asynchronous and synchronised here.
`timescale 1ns/100ps

// Contract
// [R1] Thirteen sources, each with a software-visible pending flag.
// [R2] A valid source event sets its flag, enabled or not.
// [R3] Enabled pending flag raises a request; call taken at instruction end.
// [R4] Disabled source with pending flag raises no request.
// [R5] Global enable low blocks every source.
// [R6] Per-source enables count only while global enable is high.
// [R7] Request latched before global clear may still go if next instr short.
// [R8] Global clear followed by multi-cycle instruction takes no interrupt.
// [R9] Some flags cleared by hardware on vectoring, others by software.
// [R10] Flag still set after return re-requests after one more instruction.
// [R11] Software writing one to a pending flag acts as a real request; level-mode external flags (sources 0, 2) ignore the write.
// [R12] Return resumes the interrupted program; routines end with return.
// [R13] Each external line has sense (1 edge) and polarity (1 high) bits.
// [R14] External inputs only monitor their pins, never drive them.
// [R15] Edge-mode external flag is cleared by hardware on vectoring.
// [R16] Level-mode external flag follows the active input level.
// [R17] Level requester holds line until recognised, drops before return.
// [R18] Each source has a priority bit; low after reset.
// [R19] High preempts low routine; nothing preempts a high routine.
// [R20] Higher level first; within a level lowest index wins.
// [R21] Requests sampled and decoded every clock cycle.
// [R22] Equal or lower request waits for return plus one instruction.
// [R23] One in-service marker per level, set on vector, cleared on return.
// [R24] Edge detect compares successive synchronised samples.
module tlih_handler
  import tlih_pkg::*;
(
  // Clock and reset
  input  wire logic            pclk,
  input  wire logic            presetn,
  // APB slave
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic                 pready,
  output logic [31:0]          prdata,
  output logic                 pslverr,
  // Interrupt sources
  input  wire logic [NSRC-1:0] periph_event,
  input  wire logic [1:0]      ext_request_pin,
  // CPU sequencer
  input  wire logic            instr_done,
  input  wire logic            ret_done,
  output logic                 call_strobe,
  output tlih_call_t           call_info,
  output logic                 irq_request,
  output logic [1:0]           in_service
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // Lowest set index, with valid flag on top
  function automatic logic [4:0] first_set(input logic [NSRC-1:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] ext_pack(input logic [NSRC-1:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < NSRC - PRI_SRCS; i++) begin
      r[EXT_POS[i*3 +: 3]] = v[PRI_SRCS + i];
    end
    return r;
  endfunction

  function automatic logic [NSRC-PRI_SRCS-1:0] ext_unpack(
    input logic [7:0] d);
    logic [NSRC-PRI_SRCS-1:0] r;
    r = '0;
    for (int i = 0; i < NSRC - PRI_SRCS; i++) begin
      r[i] = d[EXT_POS[i*3 +: 3]];
    end
    return r;
  endfunction

  logic            ge_reg;
  logic [NSRC-1:0] en_reg;
  logic [NSRC-1:0] lvl_reg;
  logic [NSRC-1:0] pend_reg;
  logic [NSRC-1:0] pend_next;
  logic [3:0]      cfg_reg;
  logic [1:0]      pin_s1_reg;
  logic [1:0]      pin_s2_reg;
  logic [1:0]      act_prev_reg;
  logic [3:0]      win_src_reg;
  logic            win_lvl_reg;
  logic            hold_reg;

  // APB decode: one wait state, access completes while pready is high
  wire acc     = psel & penable & pready;
  wire wr      = acc & pwrite;
  wire wr_enp  = wr & hit(paddr, OFF_EN_PRI);
  wire wr_enx  = wr & hit(paddr, OFF_EN_EXT);
  wire wr_lvp  = wr & hit(paddr, OFF_LVL_PRI);
  wire wr_lvx  = wr & hit(paddr, OFF_LVL_EXT);
  wire wr_pend = wr & hit(paddr, OFF_PEND);
  wire wr_cfg  = wr & hit(paddr, OFF_PINCFG);
  wire mapped  = hit(paddr, OFF_EN_PRI) | hit(paddr, OFF_EN_EXT)
               | hit(paddr, OFF_LVL_PRI) | hit(paddr, OFF_LVL_EXT)
               | hit(paddr, OFF_PEND) | hit(paddr, OFF_PINCFG)
               | hit(paddr, OFF_STATUS);

  wire [31:0] st_word = {23'h000000, hold_reg, win_src_reg, win_lvl_reg,
                         in_service, irq_request};
  wire [31:0] rd_val =
      hit(paddr, OFF_EN_PRI)  ? {24'h000000, ge_reg, en_reg[PRI_SRCS-1:0]} :
      hit(paddr, OFF_EN_EXT)  ? {24'h000000, ext_pack(en_reg)} :
      hit(paddr, OFF_LVL_PRI) ? {25'h0000000, lvl_reg[PRI_SRCS-1:0]} :
      hit(paddr, OFF_LVL_EXT) ? {24'h000000, ext_pack(lvl_reg)} :
      hit(paddr, OFF_PEND)    ? {19'h00000, pend_reg} :
      hit(paddr, OFF_PINCFG)  ? {28'h0000000, cfg_reg} :
      hit(paddr, OFF_STATUS)  ? st_word : 32'h00000000;

  // External pins: sense and polarity per lane
  wire [1:0] pol = {cfg_reg[POL1_BIT], cfg_reg[POL0_BIT]}; // R13
  wire [1:0] sns = {cfg_reg[SNS1_BIT], cfg_reg[SNS0_BIT]}; // R13
  wire [1:0] act = ~(pin_s2_reg ^ pol);                    // R13
  wire [1:0] ext_edge = act & ~act_prev_reg & sns;         // R24

  wire [NSRC-1:0] ext_set = (NSRC'(ext_edge[0]) << EXT0_SRC)
                          | (NSRC'(ext_edge[1]) << EXT1_SRC);
  // Logical not keeps the operand one bit wide ahead of the size cast
  wire [NSRC-1:0] lvl_mask = (NSRC'(!sns[0]) << EXT0_SRC)
                           | (NSRC'(!sns[1]) << EXT1_SRC);
  wire [NSRC-1:0] lvl_val = (NSRC'(act[0]) << EXT0_SRC)
                          | (NSRC'(act[1]) << EXT1_SRC);

  // Arbitration, evaluated every cycle
  wire [NSRC-1:0] cand    = pend_reg & en_reg & {NSRC{ge_reg}}; // R3 R4 R5 R6
  wire [NSRC-1:0] cand_hi = cand & lvl_reg;
  wire [NSRC-1:0] cand_lo = cand & ~lvl_reg;
  wire [4:0]      pick_hi = first_set(cand_hi);                 // R20
  wire [4:0]      pick_lo = first_set(cand_lo);                 // R20
  wire hi_ok = pick_hi[4] & ~in_service[1];                     // R19
  wire lo_ok = pick_lo[4] & (in_service == 2'b00);              // R19 R22
  wire take  = instr_done & irq_request & ~hold_reg;            // R3 R10
  wire req_next = (hi_ok | lo_ok) & ~take;                      // R21
  wire [3:0] src_next = hi_ok ? pick_hi[3:0] : pick_lo[3:0];    // R20

  wire [NSRC-1:0] win_hot = NSRC'(1) << win_src_reg;
  wire [NSRC-1:0] hw_clr  = take ? (HW_CLR_MASK & win_hot & ~lvl_mask)
                                 : RST_VEC;                     // R9 R15
  wire [3:0]  order  = SRC_ORDER[win_src_reg*4 +: 4];
  wire [15:0] vector = VEC_BASE + {9'h000, order, 3'h0};

  // Pending flags: event set wins over any clear; level-mode external lanes follow the input
  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++) begin : g_pend
      wire base = wr_pend ? pwdata[gi] : pend_reg[gi];          // R11
      wire set  = periph_event[gi] | ext_set[gi];               // R2
      assign pend_next[gi] = lvl_mask[gi] ? lvl_val[gi]         // R16 R17
                           : ((base & ~hw_clr[gi]) | set);      // R9
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      prdata  <= (psel & penable & ~pready & ~pwrite) ? rd_val : prdata;
      pslverr <= psel & penable & ~pready & ~mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ge_reg  <= 1'b0;
      en_reg  <= RST_VEC;
      lvl_reg <= RST_VEC;                                       // R18
      cfg_reg <= RST_CFG;
    end else begin
      if (wr_enp) begin
        ge_reg               <= pwdata[GLOB_BIT];               // R5
        en_reg[PRI_SRCS-1:0] <= pwdata[PRI_SRCS-1:0];
      end
      if (wr_enx) begin
        en_reg[NSRC-1:PRI_SRCS] <= ext_unpack(pwdata[7:0]);
      end
      if (wr_lvp) begin
        lvl_reg[PRI_SRCS-1:0] <= pwdata[PRI_SRCS-1:0];          // R18
      end
      if (wr_lvx) begin
        lvl_reg[NSRC-1:PRI_SRCS] <= ext_unpack(pwdata[7:0]);    // R18
      end
      if (wr_cfg) begin
        cfg_reg <= pwdata[3:0];
      end
    end
  end

  // Pins are only sampled, so a shared port function is undisturbed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Idle level under the reset polarity: no false flag after reset
      pin_s1_reg   <= ~{RST_CFG[POL1_BIT], RST_CFG[POL0_BIT]};
      pin_s2_reg   <= ~{RST_CFG[POL1_BIT], RST_CFG[POL0_BIT]};
      act_prev_reg <= 2'b00;
    end else begin
      pin_s1_reg   <= ext_request_pin;                          // R14
      pin_s2_reg   <= pin_s1_reg;
      act_prev_reg <= act;                                      // R24
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg <= RST_VEC;
    end else begin
      pend_reg <= pend_next;                                    // R1
    end
  end

  // Request latched from the enables of the previous cycle, so a clear
  // of the global enable still lets a boundary in the next cycle take it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_request <= 1'b0;
      win_src_reg <= 4'h0;
      win_lvl_reg <= 1'b0;
    end else begin
      irq_request <= req_next;                                  // R7 R8 R21
      win_src_reg <= src_next;
      win_lvl_reg <= hi_ok;
    end
  end

  // Return blocks the very next boundary, then the next request goes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_reg <= 1'b0;
    end else if (ret_done) begin
      hold_reg <= 1'b1;                                         // R10 R22
    end else if (instr_done) begin
      hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_service <= 2'b00;
    end else if (take) begin
      in_service[win_lvl_reg] <= 1'b1;                          // R23
    end else if (ret_done) begin
      if (in_service[1]) begin
        in_service[1] <= 1'b0;                                  // R12 R23
      end else begin
        in_service[0] <= 1'b0;                                  // R12 R23
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      call_strobe <= 1'b0;
      call_info   <= '0;
    end else begin
      call_strobe <= take;                                      // R3
      if (take) begin
        call_info <= '{vector: vector, level: win_lvl_reg,
                       src: win_src_reg};
      end
    end
  end

  a_global_gate: // R5
  assert property (@(posedge pclk) disable iff (!presetn)
    !ge_reg |=> !irq_request)
  else $error("request raised with global enable low");

  a_masked_quiet: // R4
  assert property (@(posedge pclk) disable iff (!presetn)
    ((pend_reg & en_reg) == RST_VEC) |=> !irq_request)
  else $error("request raised for disabled source");

  a_request_raised: // R3
  assert property (@(posedge pclk) disable iff (!presetn)
    (ge_reg && (pend_reg & en_reg) != RST_VEC && in_service == 2'b00
     && !take) |=> irq_request)
  else $error("enabled pending flag raised no request");

  a_clear_multi: // R8
  assert property (@(posedge pclk) disable iff (!presetn)
    $fell(ge_reg) && !instr_done |=> !take)
  else $error("interrupt taken after global clear");

  a_event_sets: // R2
  assert property (@(posedge pclk) disable iff (!presetn)
    periph_event[1] |=> pend_reg[1])
  else $error("source event did not set pending flag");

  a_soft_request: // R11
  assert property (@(posedge pclk) disable iff (!presetn)
    wr_pend && ((pwdata[NSRC-1:0] & en_reg & ~lvl_mask) != RST_VEC)
    && ge_reg && in_service == 2'b00 && !take
    |=> ##1 (irq_request || call_strobe))
  else $error("software set did not request");

  a_edge_clear: // R15
  assert property (@(posedge pclk) disable iff (!presetn)
    take && win_src_reg == 4'(EXT0_SRC) && sns[0] && !ext_edge[0]
    && !periph_event[EXT0_SRC] |=> !pend_reg[EXT0_SRC])
  else $error("edge flag not cleared on vectoring");

  a_level_follow: // R16
  assert property (@(posedge pclk) disable iff (!presetn)
    !sns[1] && $stable(cfg_reg) |=> pend_reg[EXT1_SRC] == $past(act[1]))
  else $error("level flag does not follow input");

  a_no_preempt_hi: // R19
  assert property (@(posedge pclk) disable iff (!presetn)
    in_service[1] |-> !take)
  else $error("high routine preempted");

  a_return_wait: // R10
  assert property (@(posedge pclk) disable iff (!presetn)
    ret_done ##1 instr_done |-> !take)
  else $error("request taken before one instruction after return");

  a_marker_set: // R23
  assert property (@(posedge pclk) disable iff (!presetn)
    take |=> in_service[$past(win_lvl_reg)] && call_strobe)
  else $error("in-service marker not set on vectoring");

  a_level_order: // R20
  assert property (@(posedge pclk) disable iff (!presetn)
    (cand_hi != RST_VEC) && !in_service[1] |=> win_lvl_reg)
  else $error("low level won over high level");

  a_low_waits: // R22
  assert property (@(posedge pclk) disable iff (!presetn)
    take && in_service != 2'b00 |-> win_lvl_reg)
  else $error("request taken over a routine of equal level");

  a_hw_keep: // R9
  assert property (@(posedge pclk) disable iff (!presetn)
    take && pend_reg[win_src_reg] && !HW_CLR_MASK[win_src_reg] && !wr_pend
    |=> pend_reg[$past(win_src_reg)])
  else $error("software-cleared flag lost on vectoring");

  a_take_drops: // R21
  assert property (@(posedge pclk) disable iff (!presetn)
    take |=> !irq_request)
  else $error("request still raised after vectoring");

  a_call_pulse: // R3
  assert property (@(posedge pclk) disable iff (!presetn)
    call_strobe |=> !call_strobe)
  else $error("call strobe longer than one cycle");

  a_edge_once: // R24
  assert property (@(posedge pclk) disable iff (!presetn)
    ext_edge[0] |=> !ext_edge[0])
  else $error("one pin transition gave two edge events");

  a_level_lane0: // R16
  assert property (@(posedge pclk) disable iff (!presetn)
    !sns[0] |=> pend_reg[EXT0_SRC] == $past(act[0]))
  else $error("lane 0 level flag does not follow input");

endmodule

// ==== verification/tlih_cpu_model.sv ====
// Purpose: Behavioural CPU sequencer facing the interrupt handler.
// Assumes: Instruction ends and returns are one-cycle pulses on pclk.
// Notes:   slow leaves an idle cycle after every instruction end.
`timescale 1ns/100ps
module tlih_cpu_model (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Bench control
  input  wire logic run,
  input  wire logic slow,
  input  wire logic ret_go,
  // Handler side
  input  wire logic call_strobe,
  output logic      instr_done,
  output logic      ret_done
);
  // No instruction ends in the cycle after a call strobe or a return request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_done <= 1'h0;
      ret_done   <= 1'h0;
    end else begin
      ret_done   <= ret_go;
      instr_done <= run & ~ret_go & ~call_strobe & ~(slow & instr_done);
    end
  end
endmodule

// ==== verification/two_level_interrupt_handler_test.sv ====
// Purpose: Self-checking bench for the two-level interrupt handler.
// Assumes: One wait state on APB; pins start inactive for active low.
// Notes:   Routines are played by bench writes to the pending register.
`timescale 1ns/100ps
module two_level_interrupt_handler_test
  import tlih_pkg::*;
;
  logic            pclk;
  logic            presetn;
  logic            psel, penable, pwrite, pready, pslverr;
  logic [7:0]      paddr;
  logic [31:0]     pwdata, prdata, rd;
  logic [NSRC-1:0] periph_event;
  logic [1:0]      ext_request_pin, in_service;
  logic            instr_done, ret_done, call_strobe, irq_request;
  tlih_call_t      call_info;
  logic            run, slow, ret_go, rerr;
  int              err_count, compares;

  tlih_handler u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .periph_event(periph_event), .ext_request_pin(ext_request_pin),
    .instr_done(instr_done), .ret_done(ret_done),
    .call_strobe(call_strobe), .call_info(call_info),
    .irq_request(irq_request), .in_service(in_service));

  tlih_cpu_model u_cpu (.pclk(pclk), .presetn(presetn), .run(run),
    .slow(slow), .ret_go(ret_go), .call_strobe(call_strobe),
    .instr_done(instr_done), .ret_done(ret_done));

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic timeout(string what);
    err_count++;
    $display("[ERR] %s expected answer seen none", what);
    summarize();
  endtask

  task automatic wait_n(int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'h1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) timeout("pready");
    rd = prdata;
    rerr = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic pend_is(logic [31:0] exp);
    apb(1'h0, OFF_PEND, 32'h0);
    check("pending", rd, exp);
  endtask

  task automatic wait_call(logic [15:0] vec, logic [1:0] svc);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (call_strobe !== 1'h1 && n < 50);
    if (n >= 50) timeout("call");
    check("vector", 32'(call_info.vector), 32'(vec));
    check("in_service", 32'(in_service), 32'(svc));
    check("level", 32'(call_info.level), 32'(svc[1]));
  endtask

  task automatic ret_pulse();
    @(posedge pclk);
    ret_go <= 1'h1;
    @(posedge pclk);
    ret_go <= 1'h0;
  endtask

  task automatic do_ret(logic [1:0] svc);
    ret_pulse();
    wait_n(3);
    check("in_service", 32'(in_service), 32'(svc));
  endtask

  task automatic t_reset();
    pend_is(32'h0);
    for (int a = 0; a <= 8'h1C; a += 4) begin
      apb(1'h0, 8'(a), 32'h0);
      check("reg", rd, 32'h0);
      check("slverr", 32'(rerr), 32'(a == 8'h1C));
    end
    apb(1'h1, OFF_LVL_EXT, 32'hFF);
    apb(1'h0, OFF_LVL_EXT, 32'h0);
    check("lvl_ext", rd, 32'hBD);
    apb(1'h1, OFF_LVL_PRI, 32'hFF);
    apb(1'h0, OFF_LVL_PRI, 32'h0);
    check("lvl_pri", rd, 32'h7F);
    apb(1'h1, OFF_LVL_PRI, 32'h0);
    apb(1'h1, OFF_LVL_EXT, 32'h0);
    $display("reset test done");
  endtask

  task automatic t_mask();
    slow <= 1'h1;
    apb(1'h1, OFF_EN_PRI, 32'h02);
    @(posedge pclk);
    periph_event <= 13'h0002;
    @(posedge pclk);
    periph_event <= 13'h0000;
    pend_is(32'h2);
    check("irq", 32'(irq_request), 32'h0);
    apb(1'h1, OFF_EN_PRI, 32'h80);
    wait_n(3);
    check("irq", 32'(irq_request), 32'h0);
    apb(1'h1, OFF_EN_PRI, 32'h82);
    wait_n(3);
    check("irq", 32'(irq_request), 32'h1);
    run <= 1'h1;
    wait_call(16'h000B, 2'h1);
    run <= 1'h0;
    pend_is(32'h0);
    do_ret(2'h0);
    slow <= 1'h0;
    $display("mask test done");
  endtask

  task automatic t_prio();
    run <= 1'h1;
    apb(1'h1, OFF_EN_PRI, 32'hB0);
    apb(1'h1, OFF_EN_EXT, 32'h08);
    apb(1'h1, OFF_LVL_EXT, 32'h08);
    apb(1'h1, OFF_PEND, 32'h230);
    wait_call(16'h0053, 2'h2);
    wait_n(10);
    check("in_service", 32'(in_service), 32'h2);
    apb(1'h1, OFF_PEND, 32'h030);
    ret_pulse();
    wait_call(16'h0023, 2'h1);
    wait_n(10);
    check("in_service", 32'(in_service), 32'h1);
    apb(1'h1, OFF_PEND, 32'h220);
    wait_call(16'h0053, 2'h3);
    apb(1'h1, OFF_PEND, 32'h0);
    do_ret(2'h1);
    do_ret(2'h0);
    $display("priority test done");
  endtask

  task automatic t_reenter();
    int n;
    int k;
    n = 0;
    k = 0;
    apb(1'h1, OFF_PEND, 32'h010);
    wait_call(16'h0023, 2'h1);
    ret_pulse();
    do begin
      @(posedge pclk);
      k++;
    end while (ret_done !== 1'h1 && k < 10);
    if (k >= 10) timeout("ret_done");
    while (k < 30) begin
      @(posedge pclk);
      k++;
      if (call_strobe === 1'h1) break;
      if (instr_done === 1'h1) n++;
    end
    check("reentry_call", 32'(call_strobe), 32'h1);
    check("instr_after_ret", 32'(n), 32'h2);
    apb(1'h1, OFF_PEND, 32'h0);
    do_ret(2'h0);
    run <= 1'h0;
    $display("reentry test done");
  endtask

  task automatic t_ext();
    apb(1'h1, OFF_EN_PRI, 32'h80);
    apb(1'h1, OFF_PINCFG, 32'h01);
    wait_n(6);
    pend_is(32'h1);
    ext_request_pin <= 2'h2;
    wait_n(6);
    pend_is(32'h0);
    apb(1'h1, OFF_PINCFG, 32'h00);
    wait_n(6);
    pend_is(32'h1);
    ext_request_pin <= 2'h3;
    wait_n(6);
    pend_is(32'h0);
    apb(1'h1, OFF_PINCFG, 32'h0E);
    wait_n(6);
    apb(1'h1, OFF_PEND, 32'h0);
    ext_request_pin <= 2'h0;
    wait_n(6);
    pend_is(32'h1);
    ext_request_pin <= 2'h2;
    wait_n(6);
    pend_is(32'h5);
    apb(1'h1, OFF_EN_PRI, 32'h81);
    run <= 1'h1;
    wait_call(16'h0003, 2'h1);
    run <= 1'h0;
    pend_is(32'h4);
    apb(1'h1, OFF_PEND, 32'h0);
    do_ret(2'h0);
    $display("external test done");
  endtask

  initial begin
    pclk = 1'h0;
    forever #4 pclk = ~pclk;
  end

  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    periph_event = 13'h0000;
    ext_request_pin = 2'h3;
    run = 1'h0;
    slow = 1'h0;
    ret_go = 1'h0;
    err_count = 0;
    compares = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_mask();
    t_prio();
    t_reenter();
    t_ext();
    summarize();
  end
endmodule
